// File: hw/rsc_top.sv
// Repeated-start sequencer with bus-collision detection for an I2C master.
// Assumes open-drain pads outside; the pad logic runs on clk_link_in, the
// sequencer on clk_sys_in, and only synchronised levels pass between them.
//
// Operation
// - After releasing SDA, load counter from reload bits 6:0 and count to zero.
// - On expiry release SCL; once SCL samples high, sample SDA.
// - SDA sampled low then means a collision with another master's data zero.
// - SDA sampled high then reloads the counter and counts down again.
// - SDA falling during that count is not a collision.
// - SCL falling during that count before SDA went low is a collision.
// - Both lines high at expiry: drive SDA low, reload, count again.
// - At final expiry drive SCL low regardless of its level; sequence complete.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_top #(
	parameter int CNT_W = `RSC_CNT_W
) (
	input  wire logic                     clk_sys_in,
	input  wire logic                     sys_rst_in,
	input  wire logic                     clk_link_in,
	input  wire logic                     rs_start_in,
	input  wire logic [`RSC_RELOAD_W-1:0] rate_reload_register_in,
	input  wire logic                     bcol_clear_in,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          scl_out,
	output logic                          scl_oe_n_out,
	output logic                          sda_out,
	output logic                          sda_oe_n_out,
	output logic                          busy_out,
	output logic                          done_out,
	output logic                          bcol_flag_out
);

	// Only the low seven bits of the reload register set the phase length.
	function automatic logic [CNT_W-1:0] reload_of(input logic [`RSC_RELOAD_W-1:0] r);
		logic [CNT_W-1:0] v;
		v = CNT_W'(r[`RSC_RELOAD_MSB:`RSC_RELOAD_LSB]);
		return v;
	endfunction

	// Link clock domain: reset, pin sampling and pad drivers.
	logic               link_rst;
	rsc_pkg::rsc_lines_t pin_link;
	rsc_pkg::rsc_lines_t drive_link;
	logic               scl_oe_n_r;
	logic               sda_oe_n_r;
	logic               scl_out_r;
	logic               sda_out_r;

	rsc_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_link_rst_sync (
		.clk_in (clk_link_in),
		.rst_in (1'b0),
		.d_in   (sys_rst_in),
		.q_out  (link_rst)
	);

	rsc_sync #(
		.WIDTH   (2),
		.RST_VAL (2'h3)
	) u_pin_sync (
		.clk_in (clk_link_in),
		.rst_in (link_rst),
		.d_in   ({scl_in, sda_in}),
		.q_out  (pin_link)
	);

	logic scl_drive_r;
	logic sda_drive_r;

	rsc_sync #(
		.WIDTH   (2),
		.RST_VAL (2'h0)
	) u_drive_sync (
		.clk_in (clk_link_in),
		.rst_in (link_rst),
		.d_in   ({scl_drive_r, sda_drive_r}),
		.q_out  (drive_link)
	);

	// Enables are active low: a low enable pulls the wire to the constant zero.
	always_ff @(posedge clk_link_in) begin
		if (link_rst) begin
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end else begin
			scl_oe_n_r <= ~drive_link.scl;
			sda_oe_n_r <= ~drive_link.sda;
		end
	end

	always_ff @(posedge clk_link_in) begin
		if (link_rst) begin
			scl_out_r <= 1'b0;
			sda_out_r <= 1'b0;
		end else begin
			scl_out_r <= 1'b0;
			sda_out_r <= 1'b0;
		end
	end

	assign scl_out      = scl_out_r;
	assign sda_out      = sda_out_r;
	assign scl_oe_n_out = scl_oe_n_r;
	assign sda_oe_n_out = sda_oe_n_r;

	// System clock domain: the sequencer itself.
	rsc_pkg::rsc_lines_t line_s;

	rsc_sync #(
		.WIDTH   (2),
		.RST_VAL (2'h3)
	) u_line_sync (
		.clk_in (clk_sys_in),
		.rst_in (sys_rst_in),
		.d_in   (pin_link),
		.q_out  (line_s)
	);

	rsc_pkg::rsc_state_t state_r;
	rsc_pkg::rsc_state_t state_nxt;
	logic [CNT_W-1:0]    count_r;
	logic                expired;
	logic                sda_seen_low_r;
	logic                collide;
	logic                busy_r;
	logic                done_r;
	logic                bcol_r;

	assign expired = (count_r == CNT_W'(`RSC_CNT_ZERO));

	always_comb begin
		state_nxt = state_r;
		collide   = 1'b0;
		unique case (state_r)
			rsc_pkg::RSC_IDLE: begin
				if (rs_start_in) begin
					state_nxt = rsc_pkg::RSC_SDA_REL;
				end
			end
			rsc_pkg::RSC_SDA_REL: begin
				if (expired) begin
					state_nxt = rsc_pkg::RSC_SCL_REL;
				end
			end
			rsc_pkg::RSC_SCL_REL: begin
				// A slave may stretch SCL; there is no timeout on this wait.
				if (line_s.scl) begin
					if (!line_s.sda) begin
						collide   = 1'b1;
						state_nxt = rsc_pkg::RSC_IDLE;
					end else begin
						state_nxt = rsc_pkg::RSC_HOLD_HI;
					end
				end
			end
			rsc_pkg::RSC_HOLD_HI: begin
				if (!line_s.scl && !line_s.sda && !sda_seen_low_r) begin
					collide   = 1'b1;
					state_nxt = rsc_pkg::RSC_IDLE;
				end else if (!line_s.scl && !sda_seen_low_r) begin
					collide   = 1'b1;
					state_nxt = rsc_pkg::RSC_IDLE;
				end else if (expired) begin
					state_nxt = rsc_pkg::RSC_SDA_LOW;
				end
			end
			rsc_pkg::RSC_SDA_LOW: begin
				if (expired) begin
					state_nxt = rsc_pkg::RSC_IDLE;
				end
			end
			default: begin
				state_nxt = rsc_pkg::RSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state_r <= rsc_pkg::RSC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// RSC_SDA_REL, RSC_HOLD_HI and RSC_SDA_LOW load on entry and count down to zero; zero holds.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			count_r <= CNT_W'(`RSC_CNT_ZERO);
		end else if (state_r == rsc_pkg::RSC_IDLE && state_nxt == rsc_pkg::RSC_SDA_REL) begin
			count_r <= reload_of(rate_reload_register_in);
		end else if (state_r == rsc_pkg::RSC_SCL_REL && state_nxt == rsc_pkg::RSC_HOLD_HI) begin
			count_r <= reload_of(rate_reload_register_in);
		end else if (state_r == rsc_pkg::RSC_HOLD_HI && state_nxt == rsc_pkg::RSC_SDA_LOW) begin
			count_r <= reload_of(rate_reload_register_in);
		end else if (!expired) begin
			count_r <= count_r - CNT_W'(1);
		end
	end

	// No two masters pull SDA low in the same instant, so an SDA fall seen
	// first means another master won cleanly and SCL falling is no collision.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sda_seen_low_r <= 1'b0;
		end else if (state_r != rsc_pkg::RSC_HOLD_HI) begin
			sda_seen_low_r <= 1'b0;
		end else if (!line_s.sda) begin
			sda_seen_low_r <= 1'b1;
		end
	end

	// SCL stays held low after completion, through the next start, until that sequence leaves RSC_SDA_REL.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			scl_drive_r <= 1'b0;
		end else if (collide) begin
			scl_drive_r <= 1'b0;
		end else if (state_nxt == rsc_pkg::RSC_SCL_REL) begin
			scl_drive_r <= 1'b0;
		end else if (state_r == rsc_pkg::RSC_SDA_LOW && expired) begin
			scl_drive_r <= 1'b1;
		end else if (state_r == rsc_pkg::RSC_IDLE && rs_start_in) begin
			scl_drive_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sda_drive_r <= 1'b0;
		end else if (collide) begin
			sda_drive_r <= 1'b0;
		end else if (state_r == rsc_pkg::RSC_IDLE && rs_start_in) begin
			sda_drive_r <= 1'b0;
		end else if (state_nxt == rsc_pkg::RSC_SDA_LOW) begin
			sda_drive_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			busy_r <= (state_nxt != rsc_pkg::RSC_IDLE);
			done_r <= (state_r == rsc_pkg::RSC_SDA_LOW) && expired;
		end
	end

	// A collision in the same cycle as a clear still sets the flag.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bcol_r <= 1'b0;
		end else if (collide) begin
			bcol_r <= 1'b1;
		end else if (bcol_clear_in) begin
			bcol_r <= 1'b0;
		end
	end

	assign busy_out      = busy_r;
	assign done_out      = done_r;
	assign bcol_flag_out = bcol_r;

endmodule

`default_nettype wire

// File: hw/rsc_cfg.svh
// Constants for the repeated-start collision sequencer.
// Assumes inclusion by bare name from files under hw/.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_RELOAD_W   8
`define RSC_RELOAD_MSB 6
`define RSC_RELOAD_LSB 0
`define RSC_CNT_W      7
`define RSC_CNT_ZERO   7'h00
`define RSC_SYNC_DEPTH 2

`endif

// File: hw/rsc_pkg.sv
// Types shared by the repeated-start collision sequencer.
// Assumes no other package; all users refer to names with rsc_pkg::.
package rsc_pkg;

	typedef enum logic [2:0] {
		RSC_IDLE    = 3'h0,
		RSC_SDA_REL = 3'h1,
		RSC_SCL_REL = 3'h3,
		RSC_HOLD_HI = 3'h2,
		RSC_SDA_LOW = 3'h6
	} rsc_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} rsc_lines_t;

endpackage

// File: hw/rsc_sync.sv
// Multi-bit two-flop level synchroniser.
// Assumes each bit is an independent level; stage one is read only by stage two.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] stage_r [`RSC_SYNC_DEPTH];

	genvar i;
	generate
		for (i = 0; i < `RSC_SYNC_DEPTH; i++) begin : g_stage
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					stage_r[i] <= RST_VAL;
				end else if (i == 0) begin
					stage_r[i] <= d_in;
				end else begin
					stage_r[i] <= stage_r[(i == 0) ? 0 : i - 1];
				end
			end
		end
	endgenerate

	assign q_out = stage_r[`RSC_SYNC_DEPTH-1];

endmodule

`default_nettype wire

// File: sim/rsc_top_assertions.sv
// Port checker for the repeated-start sequencer.
// Assumes binding to rsc_top; all checks run in the sys domain.
`timescale 1ns/1ps
`default_nettype none
module rsc_top_chk (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic rs_start_in,
	input wire logic bcol_clear_in,
	input wire logic scl_out,
	input wire logic scl_oe_n_out,
	input wire logic sda_out,
	input wire logic sda_oe_n_out,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic bcol_flag_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	a_busy_on_start: assert property (rs_start_in && !busy_out |=> busy_out)
		else $error("start not taken");
	// Pad enables lag the sequencer by the link crossing, hence the window.
	a_sda_let_go: assert property ($rose(busy_out) |-> ##[0:8] sda_oe_n_out)
		else $error("sda not released");
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done too long");
	a_done_idle: assert property (done_out |-> ##[0:1] !busy_out)
		else $error("busy after done");
	a_done_drive: assert property (done_out |-> ##[0:6] (!scl_oe_n_out && !sda_oe_n_out))
		else $error("lines not driven");
	a_col_release: assert property ($rose(bcol_flag_out) |-> ##[0:6] (scl_oe_n_out && sda_oe_n_out))
		else $error("lines not released");
	a_col_abort: assert property ($rose(bcol_flag_out) |-> !done_out ##1 !busy_out)
		else $error("collision did not abort");
	a_flag_hold: assert property (bcol_flag_out && !bcol_clear_in |=> bcol_flag_out)
		else $error("flag lost");
	a_flag_clear: assert property (bcol_flag_out && bcol_clear_in && !busy_out |=> !bcol_flag_out)
		else $error("flag not cleared");
	a_drive_zero: assert property (!scl_out && !sda_out)
		else $error("pad drives high");
endmodule
bind rsc_top rsc_top_chk u_chk (.clk_sys_in, .sys_rst_in, .rs_start_in, .bcol_clear_in,
	.scl_out, .scl_oe_n_out, .sda_out, .sda_oe_n_out, .busy_out, .done_out, .bcol_flag_out);
`default_nettype wire

// File: sim/rsc_bus_model.sv
// Rest of the bus: pull-ups plus a second master that acts per mode.
// Assumes open-drain enables from the sequencer; mode set by the bench.
`timescale 1ns/1ps
`default_nettype none
module rsc_bus_model (
	input  wire logic       clk_in,
	input  wire logic [2:0] mode_in,
	input  wire logic       scl_oe_n_in,
	input  wire logic       sda_oe_n_in,
	output logic            scl_out,
	output logic            sda_out
);
	logic [7:0] cnt_r = 8'h00;
	logic       scl_low;
	logic       sda_low;
	// Link cycles since SCL was let go; saturates so a long stall stays put.
	always_ff @(posedge clk_in) begin
		if (!scl_oe_n_in)
			cnt_r <= 8'h00;
		else if (cnt_r != 8'hff)
			cnt_r <= cnt_r + 8'h01;
	end
	assign scl_low = (mode_in == 3'h4 && cnt_r < 8'h1e) || (mode_in == 3'h2 && cnt_r > 8'h14);
	assign sda_low = mode_in == 3'h1 || (mode_in == 3'h3 && cnt_r > 8'h14);
	// Released lines read high through the pull-ups.
	assign scl_out = scl_oe_n_in && !scl_low;
	assign sda_out = sda_oe_n_in && !sda_low;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Bench: repeated starts against a scripted second master.
// Assumes rsc_top and rsc_bus_model; results come back in issue order.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk = 1'b0;
	logic       clk_link = 1'b0;
	logic       rst = 1'b1;
	logic       start = 1'b0;
	logic       clr = 1'b0;
	logic [7:0] reload = 8'h00;
	logic [2:0] mode = 3'h0;
	logic       scl_w, sda_w, scl_oe_n, sda_oe_n, busy, done, flag;
	logic       flag_d = 1'b0;
	int         fail_count = 0;
	int         samples_checked = 0;
	int         seed = 95908;
	logic       exp_q[$];
	rsc_top u_dut (.clk_sys_in(clk), .sys_rst_in(rst), .clk_link_in(clk_link),
		.rs_start_in(start), .rate_reload_register_in(reload), .bcol_clear_in(clr),
		.scl_in(scl_w), .sda_in(sda_w), .scl_out(), .scl_oe_n_out(scl_oe_n), .sda_out(),
		.sda_oe_n_out(sda_oe_n), .busy_out(busy), .done_out(done), .bcol_flag_out(flag));
	rsc_bus_model u_bus (.clk_in(clk_link), .mode_in(mode), .scl_oe_n_in(scl_oe_n),
		.sda_oe_n_in(sda_oe_n), .scl_out(scl_w), .sda_out(sda_w));
	initial forever #10 clk = ~clk;
	initial begin
		#3.7;
		forever #6 clk_link = ~clk_link;
	end
	task automatic chk(input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// An unexpected result meets an unknown expectation and so always counts.
	always @(negedge clk) begin
		if (!rst && (done || (flag && !flag_d)))
			chk(exp_q.size() > 0 ? exp_q.pop_front() : 1'bx, flag);
		flag_d <= flag;
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 10; i++) begin
			mode = 3'(i % 5);
			reload = (i == 5) ? 8'h80 : 8'h18 + (8'($random(seed)) & 8'h8f);
			exp_q.push_back(mode == 3'h1 || mode == 3'h2);
			start = 1'b1;
			@(negedge clk) start = 1'b0;
			// A second request while busy must be ignored.
			@(negedge clk) start = 1'b1;
			@(negedge clk) start = 1'b0;
			for (int k = 0; k < 3000 && busy !== 1'b0; k++)
				@(negedge clk);
			// A sequence that never ends is a hang, not a pass.
			if (busy !== 1'b0)
				fail_count++;
			@(negedge clk) clr = 1'b1;
			@(negedge clk) clr = 1'b0;
			chk(1'b0, flag);
		end
		chk(1'b1, exp_q.size() == 0);
		wrap_up();
	end
	initial begin
		#400000;
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
